// [logic/lef_event_flags.sv]
// link event flags: interrupt status bits 2..7, mask, summary, ahb-lite slave
// assumes event inputs come from link logic on hclk, pulses one cycle, except tx_idle, which is a level
//
// Contract
// - phy read flag sets when returned phy value loads the access register
// - self-id complete flag sets once a whole bus reset sequence finishes
// - with self-id receive on, completion waits until self-id packets are stored
// - transmitter ready flag sets when the transmitter becomes idle
// - ready without acknowledge on nonbroadcast async packet means retry when bus idles
// - receiver data flag sets per packet, or per block with trigger enabled
// - during self-id phase receiver data flag sets after every self-id reception
// - command reset flag sets on a received reset-command quadlet write
// - that write is the quadlet write to the node's reset-start register
// - host writes back the read value; each one written clears its flag
// - summary bit zero is the or of flags gated by their mask bits
// - phy reset started flag sets when a bus reset begins
`timescale 1ns/100ps
`default_nettype none
module lef_event_flags (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic [31:0]                        hrdata,
    input  wire logic                          phy_read_valid,
    input  wire logic [lef_pkg::PHY_DATA_W-1:0] phy_read_data,
    input  wire logic                          phy_reset_start,
    input  wire logic                          bus_reset_done,
    input  wire logic                          grf_selfid_busy,
    input  wire logic                          tx_idle,
    input  wire logic                          tx_async_nonbcast,
    input  wire logic                          acknowledge_valid,
    input  wire logic                          bus_idle,
    input  wire logic                          rx_packet_done,
    input  wire logic                          rx_block_done,
    input  wire logic                          self_id_phase,
    input  wire logic                          rx_selfid_done,
    input  wire logic                          rx_req_valid,
    input  wire logic [3:0]                    rx_tcode,
    input  wire logic [47:0]                   rx_dest_offset,
    output logic                               arb_retry,
    output logic                               self_id_receive_enable,
    output logic                               trigger_enable,
    output logic                               irq
);
    import lef_pkg::*;

    lef_bus_state_e             state_reg;
    logic [ADDR_W-1:0]          addr_reg;
    logic [31:0]                hrdata_reg;
    logic [NFLAG-1:0]           mask_reg;
    logic [1:0]                 ctrl_reg;
    logic [PHY_DATA_W-1:0]      phy_data_reg;
    logic                       sid_pending_reg;
    logic                       tx_idle_reg;
    logic                       retry_pending_reg;
    logic                       arb_retry_reg;
    logic [NFLAG-1:0]           flags;
    logic [NFLAG-1:0]           ev_set;
    logic [NFLAG-1:0]           wr_clr;
    logic                       addr_phase;
    logic                       wr_en;
    logic                       summary;
    logic                       ev_selfid;
    logic                       ev_tx;
    logic                       ev_rx;
    logic                       ev_cmd;
    logic [31:0]                rd_mux;

    // bus slave: writes take no wait, reads one wait to register hrdata
    assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign wr_en      = (state_reg == ST_WRITE);
    assign hreadyout  = (state_reg != ST_RWAIT);
    assign hresp      = HRESP_OKAY;
    assign hrdata     = hrdata_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            addr_reg  <= '0;
        end else begin
            case (state_reg)
                ST_RWAIT: begin
                    state_reg <= ST_RDONE;
                end
                ST_IDLE, ST_WRITE, ST_RDONE: begin
                    if (addr_phase) begin
                        state_reg <= hwrite ? ST_WRITE : ST_RWAIT;
                        addr_reg  <= haddr[ADDR_W-1:0];
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // unmapped addresses read zero and ignore writes
    always_comb begin
        rd_mux = RDATA_RESET;
        case (addr_reg)
            ADDR_ACK: begin
                rd_mux[BIT_ACK_VALID] = acknowledge_valid;
            end
            ADDR_CTRL: begin
                rd_mux[BIT_TRIG_EN]   = ctrl_reg[0];
                rd_mux[BIT_SID_RX_EN] = ctrl_reg[1];
            end
            ADDR_INT_STATUS: begin
                rd_mux[FLAG_LSB +: NFLAG] = flags;
                rd_mux[BIT_SUMMARY]       = summary;
            end
            ADDR_INT_MASK: begin
                rd_mux[FLAG_LSB +: NFLAG] = mask_reg;
            end
            ADDR_PHY_ACCESS: begin
                rd_mux[PHY_DATA_W-1:0] = phy_data_reg;
            end
            default: begin
                rd_mux = RDATA_RESET;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= RDATA_RESET;
        end else if (state_reg == ST_RWAIT) begin
            hrdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_reg <= MASK_RESET;
            ctrl_reg <= CTRL_RESET;
        end else if (wr_en) begin
            if (addr_reg == ADDR_INT_MASK) begin
                mask_reg <= hwdata[FLAG_LSB +: NFLAG];
            end
            if (addr_reg == ADDR_CTRL) begin
                ctrl_reg <= {hwdata[BIT_SID_RX_EN], hwdata[BIT_TRIG_EN]};
            end
        end
    end

    assign trigger_enable         = ctrl_reg[0];
    assign self_id_receive_enable = ctrl_reg[1];

    // phy access register catches the returned value with its flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phy_data_reg <= PHY_RESET;
        end else if (phy_read_valid) begin
            phy_data_reg <= phy_read_data;
        end
    end

    // completion held back while self-id quadlets still head for the fifo
    assign ev_selfid = (sid_pending_reg || bus_reset_done)
                       && !(self_id_receive_enable && grf_selfid_busy);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sid_pending_reg <= 1'b0;
        end else begin
            sid_pending_reg <= (sid_pending_reg || bus_reset_done) && !ev_selfid;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // transmitter idles high; a low reset value would fake a ready edge
            tx_idle_reg <= 1'b1;
        end else begin
            tx_idle_reg <= tx_idle;
        end
    end

    assign ev_tx = tx_idle && !tx_idle_reg;

    // lost arbitration: request the bus again on the next idle bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            retry_pending_reg <= 1'b0;
            arb_retry_reg     <= 1'b0;
        end else begin
            arb_retry_reg <= retry_pending_reg && bus_idle;
            if (ev_tx && tx_async_nonbcast && !acknowledge_valid) begin
                retry_pending_reg <= 1'b1;
            end else if (bus_idle) begin
                retry_pending_reg <= 1'b0;
            end
        end
    end

    assign arb_retry = arb_retry_reg;

    // self-id phase overrides block grouping
    assign ev_rx = self_id_phase ? rx_selfid_done
                 : (trigger_enable ? rx_block_done : rx_packet_done);

    assign ev_cmd = rx_req_valid && (rx_tcode == TCODE_QUAD_WRITE)
                    && (rx_dest_offset == RESET_START_OFFSET);

    always_comb begin
        ev_set                 = '0;
        ev_set[FLAG_PHY_READ]  = phy_read_valid;
        ev_set[FLAG_PHY_RESET] = phy_reset_start;
        ev_set[FLAG_SELF_ID]   = ev_selfid;
        ev_set[FLAG_TX_READY]  = ev_tx;
        ev_set[FLAG_RX_DATA]   = ev_rx;
        ev_set[FLAG_CMD_RESET] = ev_cmd;
    end

    // write-back of the read value clears exactly the ones written
    assign wr_clr = (wr_en && addr_reg == ADDR_INT_STATUS)
                    ? hwdata[FLAG_LSB +: NFLAG] : '0;

    lef_flag_cell #(
        .W         (NFLAG),
        .RESET_VAL (FLAGS_RESET)
    ) u_flags (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set     (ev_set),
        .clr     (wr_clr),
        .flag    (flags)
    );

    assign summary = |(flags & mask_reg);
    assign irq     = summary;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_phy_read;
        phy_read_valid |=> flags[FLAG_PHY_READ] && phy_data_reg == $past(phy_read_data);
    endproperty
    a_phy_read: assert property (p_phy_read) else $error("phy read flag or data missing");

    property p_phy_reset;
        phy_reset_start |=> flags[FLAG_PHY_RESET];
    endproperty
    a_phy_reset: assert property (p_phy_reset) else $error("phy reset flag not set");

    property p_sid_done;
        bus_reset_done && !self_id_receive_enable |=> flags[FLAG_SELF_ID];
    endproperty
    a_sid_done: assert property (p_sid_done) else $error("self-id complete not set");

    property p_sid_wait;
        self_id_receive_enable && grf_selfid_busy && !flags[FLAG_SELF_ID]
            |=> !flags[FLAG_SELF_ID];
    endproperty
    a_sid_wait: assert property (p_sid_wait) else $error("completion before fifo fill");

    property p_tx_ready;
        !tx_idle ##1 tx_idle |=> flags[FLAG_TX_READY];
    endproperty
    a_tx_ready: assert property (p_tx_ready) else $error("transmitter ready not set");

    property p_retry;
        (ev_tx && tx_async_nonbcast && !acknowledge_valid) ##1 bus_idle |=> arb_retry;
    endproperty
    a_retry: assert property (p_retry) else $error("no arbitration retry");

    property p_retry_cause;
        arb_retry |-> $past(bus_idle);
    endproperty
    a_retry_cause: assert property (p_retry_cause) else $error("retry on busy bus");

    property p_rx_block;
        !self_id_phase && trigger_enable && rx_block_done |=> flags[FLAG_RX_DATA];
    endproperty
    a_rx_block: assert property (p_rx_block) else $error("block did not set rx flag");

    property p_rx_selfid;
        self_id_phase && rx_selfid_done |=> flags[FLAG_RX_DATA];
    endproperty
    a_rx_selfid: assert property (p_rx_selfid) else $error("self-id rx flag missing");

    property p_cmd;
        rx_req_valid && rx_tcode == TCODE_QUAD_WRITE
            && rx_dest_offset == RESET_START_OFFSET |=> flags[FLAG_CMD_RESET];
    endproperty
    a_cmd: assert property (p_cmd) else $error("command reset not flagged");

    property p_cmd_only;
        !flags[FLAG_CMD_RESET] && !(rx_req_valid && rx_dest_offset == RESET_START_OFFSET)
            |=> !flags[FLAG_CMD_RESET];
    endproperty
    a_cmd_only: assert property (p_cmd_only) else $error("command reset from wrong write");

    property p_summary_read;
        state_reg == ST_RWAIT && addr_reg == ADDR_INT_STATUS
            |=> hrdata[BIT_SUMMARY] == $past(irq);
    endproperty
    a_summary_read: assert property (p_summary_read) else $error("summary bit wrong");

    c_selfid_wait: cover property (bus_reset_done && grf_selfid_busy ##[1:20] ev_selfid);
    c_retry: cover property (ev_tx && !acknowledge_valid ##[1:20] arb_retry);
    c_clear_race: cover property (|(wr_clr & ev_set));
    c_irq: cover property (!irq ##1 irq);
endmodule
`default_nettype wire

// [logic/lef_flag_cell.sv]
// sticky event flags, one per lane, cleared by a write of one
// assumes set and clear are single-cycle strobes on hclk
`timescale 1ns/100ps
`default_nettype none
module lef_flag_cell #(
    parameter int unsigned           W          = 6,
    parameter logic [W-1:0]          RESET_VAL  = '0
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flag
);
    logic [W-1:0] flag_reg;
    logic [W-1:0] flag_next;

    // set beats clear so an event in the clearing cycle survives
    always_comb begin
        flag_next = (flag_reg & ~clr) | set;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_reg <= RESET_VAL;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_chk
            property p_hold;
                flag_reg[i] && !clr[i] |=> flag_reg[i];
            endproperty
            a_hold: assert property (p_hold) else $error("flag dropped without clear");
            property p_clear;
                clr[i] && !set[i] |=> !flag_reg[i];
            endproperty
            a_clear: assert property (p_clear) else $error("write of one did not clear");
            property p_set_wins;
                set[i] && clr[i] |=> flag_reg[i];
            endproperty
            a_set_wins: assert property (p_set_wins) else $error("event lost to clear");
        end
    endgenerate
endmodule
`default_nettype wire

// [shared/lef_pkg.sv]
// constants for the link event flag block: map, field positions, resets
// assumes a 32-bit ahb-lite slave decoding the low byte of haddr
package lef_pkg;
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  ADDR_ACK        = 8'h04;
    localparam logic [7:0]  ADDR_CTRL       = 8'h08;
    localparam logic [7:0]  ADDR_INT_STATUS = 8'h0c;
    localparam logic [7:0]  ADDR_INT_MASK   = 8'h10;
    localparam logic [7:0]  ADDR_PHY_ACCESS = 8'h24;

    // status and mask layout
    localparam int unsigned BIT_SUMMARY     = 0;
    localparam int unsigned FLAG_LSB        = 2;
    localparam int unsigned NFLAG           = 6;
    localparam int unsigned FLAG_PHY_READ   = 0;
    localparam int unsigned FLAG_PHY_RESET  = 1;
    localparam int unsigned FLAG_SELF_ID    = 2;
    localparam int unsigned FLAG_TX_READY   = 3;
    localparam int unsigned FLAG_RX_DATA    = 4;
    localparam int unsigned FLAG_CMD_RESET  = 5;

    // ack register and control register fields
    localparam int unsigned BIT_ACK_VALID   = 31;
    localparam int unsigned BIT_TRIG_EN     = 1;
    localparam int unsigned BIT_SID_RX_EN   = 2;
    localparam int unsigned PHY_DATA_W      = 8;

    localparam logic [NFLAG-1:0]      FLAGS_RESET = 6'h00;
    localparam logic [NFLAG-1:0]      MASK_RESET  = 6'h00;
    localparam logic [1:0]            CTRL_RESET  = 2'h0;
    localparam logic [PHY_DATA_W-1:0] PHY_RESET   = 8'h00;
    localparam logic [31:0]           RDATA_RESET = 32'h0000_0000;

    // received request decode
    localparam logic [3:0]  TCODE_QUAD_WRITE   = 4'h0;
    localparam logic [47:0] RESET_START_OFFSET = 48'hffff_f000_000c;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_RWAIT = 4'b0100,
        ST_RDONE = 4'b1000
    } lef_bus_state_e;
endpackage

// [verif/lef_host_model.sv]
// host model: ahb-lite master issuing single word reads and writes
// assumes one slave whose hreadyout is also the bus hready
`timescale 1ns/100ps
`default_nettype none
module lef_host_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    import lef_pkg::*;
    logic [31:0] rd_seen;

    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        rd_seen = 32'h0000_0000;
    end

    // ready and read data taken at the rising edge, before that edge's updates land
    task automatic wait_ready();
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
        rd_seen = hrdata;
    endtask

    // one whole word; the address phase holds until ready, then data phase
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = rd_seen;
        hsel <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the link event flags block
// assumes the host model drives the bus and this module drives the link events
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("[ERR] %0t got %h exp %h", $time, got, exp); \
    end \
end
module testbench;
    import lef_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [7:0]  ev;
    logic [7:0]  phy_read_data;
    logic        grf_selfid_busy;
    logic        tx_async_nonbcast;
    logic        acknowledge_valid;
    logic        bus_idle;
    logic        self_id_phase;
    logic [3:0]  rx_tcode;
    logic [47:0] rx_dest_offset;
    logic        arb_retry;
    logic        self_id_receive_enable;
    logic        trigger_enable;
    logic        irq;
    int          fails = 0;
    int          compares = 0;
    int          cycles = 0;
    int          retries = 0;
    localparam logic [7:0] ST = ADDR_INT_STATUS;

    always #4 hclk = ~hclk;

    lef_host_model i_lef_host_model (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    // ev lanes: phy read, phy reset, reset done, tx idle, packet, request, block, self-id
    lef_event_flags i_lef_event_flags (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .phy_read_valid(ev[0]), .phy_read_data(phy_read_data), .phy_reset_start(ev[1]),
        .bus_reset_done(ev[2]), .grf_selfid_busy(grf_selfid_busy), .tx_idle(ev[3]),
        .tx_async_nonbcast(tx_async_nonbcast), .acknowledge_valid(acknowledge_valid),
        .bus_idle(bus_idle), .rx_packet_done(ev[4]), .rx_block_done(ev[6]),
        .self_id_phase(self_id_phase), .rx_selfid_done(ev[7]), .rx_req_valid(ev[5]),
        .rx_tcode(rx_tcode), .rx_dest_offset(rx_dest_offset), .arb_retry(arb_retry),
        .self_id_receive_enable(self_id_receive_enable), .trigger_enable(trigger_enable),
        .irq(irq));

    always @(posedge hclk) begin
        if (arb_retry === 1'b1) begin
            retries++;
        end
    end

    task automatic stop_test();
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ceiling far above the few hundred cycles the scenarios need
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            stop_test();
        end
    end

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        i_lef_host_model.xfer(a, 1'b0, 32'h0000_0000, q);
        `CHK(q, e)
        `CHK(hresp, HRESP_OKAY)
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        i_lef_host_model.xfer(a, 1'b1, d, q);
        // write lands at the closing edge; one more edge before anyone looks
        @(posedge hclk);
    endtask

    task automatic fire(input int k);
        @(posedge hclk);
        ev <= 8'h01 << k;
        @(posedge hclk);
        ev <= 8'h00;
        @(posedge hclk);
    endtask

    task automatic t_reset();
        rd(ST, 32'h0000_0000);
        rd(ADDR_INT_MASK, 32'h0000_0000);
        rd(ADDR_CTRL, 32'h0000_0000);
        rd(8'h40, 32'h0000_0000);
        `CHK(irq, 1'b0)
    endtask

    task automatic t_each();
        for (int k = 0; k < 6; k++) begin
            fire(k);
            fire(k);
            rd(ST, 32'h1 << (k + 2));
            wr(ST, 32'h0000_0000);
            rd(ST, 32'h1 << (k + 2));
            wr(ST, 32'h1 << (k + 2));
            rd(ST, 32'h0000_0000);
        end
        rd(ADDR_PHY_ACCESS, 32'h0000_00a5);
    endtask

    task automatic t_irq();
        wr(ADDR_INT_MASK, 32'h0000_00fc);
        rd(ADDR_INT_MASK, 32'h0000_00fc);
        fire(3);
        `CHK(irq, 1'b1)
        rd(ST, 32'h0000_0021);
        wr(ST, 32'h0000_0021);
        `CHK(irq, 1'b0)
        wr(ADDR_INT_MASK, 32'h0000_0008);
        fire(4);
        `CHK(irq, 1'b0)
        rd(ST, 32'h0000_0040);
        wr(ST, 32'h0000_0040);
        wr(ADDR_INT_MASK, 32'h0000_0000);
    endtask

    // self-id completion must wait for the fifo to hold the packets
    task automatic t_selfid();
        wr(ADDR_CTRL, 32'h0000_0004);
        `CHK(self_id_receive_enable, 1'b1)
        grf_selfid_busy <= 1'b1;
        fire(2);
        rd(ST, 32'h0000_0000);
        grf_selfid_busy <= 1'b0;
        repeat (2) @(posedge hclk);
        rd(ST, 32'h0000_0010);
        wr(ST, 32'h0000_0010);
        wr(ADDR_CTRL, 32'h0000_0000);
    endtask

    task automatic t_rx();
        wr(ADDR_CTRL, 32'h0000_0002);
        `CHK(trigger_enable, 1'b1)
        fire(4);
        rd(ST, 32'h0000_0000);
        fire(6);
        rd(ST, 32'h0000_0040);
        wr(ST, 32'h0000_0040);
        wr(ADDR_CTRL, 32'h0000_0000);
        self_id_phase <= 1'b1;
        fire(4);
        rd(ST, 32'h0000_0000);
        fire(7);
        rd(ST, 32'h0000_0040);
        wr(ST, 32'h0000_0040);
        fire(7);
        rd(ST, 32'h0000_0040);
        wr(ST, 32'h0000_0040);
        self_id_phase <= 1'b0;
    endtask

    task automatic t_cmd();
        rx_tcode <= 4'h1;
        fire(5);
        rd(ST, 32'h0000_0000);
        rx_tcode <= TCODE_QUAD_WRITE;
        rx_dest_offset <= RESET_START_OFFSET ^ 48'h0000_0000_0004;
        fire(5);
        rd(ST, 32'h0000_0000);
        rx_dest_offset <= RESET_START_OFFSET;
    endtask

    // a lost arbitration retries only once the bus goes idle
    task automatic t_retry();
        tx_async_nonbcast <= 1'b1;
        bus_idle <= 1'b0;
        fire(3);
        repeat (4) @(posedge hclk);
        `CHK(retries, 0)
        bus_idle <= 1'b1;
        repeat (4) @(posedge hclk);
        `CHK(retries, 1)
        wr(ST, 32'h0000_0020);
        acknowledge_valid <= 1'b1;
        fire(3);
        repeat (4) @(posedge hclk);
        `CHK(retries, 1)
        rd(ADDR_ACK, 32'h8000_0000);
        rd(ST, 32'h0000_0020);
        wr(ST, 32'h0000_0020);
    endtask

    initial begin
        hresetn = 1'b0;
        ev = 8'h00;
        phy_read_data = 8'ha5;
        grf_selfid_busy = 1'b0;
        tx_async_nonbcast = 1'b0;
        acknowledge_valid = 1'b0;
        bus_idle = 1'b0;
        self_id_phase = 1'b0;
        rx_tcode = TCODE_QUAD_WRITE;
        rx_dest_offset = RESET_START_OFFSET;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_each();
        t_irq();
        t_selfid();
        t_rx();
        t_cmd();
        t_retry();
        stop_test();
    end
endmodule
`default_nettype wire
